//--- logic/pcg_config_regs.sv
// Purpose : Power, clock, reference trim and channel-4 gain configuration registers
// Assumes : Register port driven by the serial-port controller on clk_sys_in
// Notes   : Analog effects live outside; this block only holds and drives the settings
//
// Summary of operation
// [RL1] Power bits 11..9 read 1 while clock, digital1, digital2 regulators are on.
// [RL2] Power bits 8..6 switch off those regulators; system then supplies rails.
// [RL3] Power bit 5 disables the internal reference resistor for external use.
// [RL4] Power bit 4 powers down the bandgap reference and channel bias.
// [RL5] Power bits 3..0 disable output current, bit 3 channel 1 to bit 0 channel 4.
// [RL6] Clock bits 11..8 gate each channel analog clock, bit 11 channel 1.
// [RL7] Clock bit 7 stops the core digital clock.
// [RL8] Clock bit 6 enters very low power clock mode.
// [RL9] Clock bit 5 powers down the clock receiver; no clocks remain.
// [RL10] Clock bit 4 selects low-power receiver; falling edge degraded.
// [RL11] Clock bits 3..0 invert each channel clock by 180 degrees, bit 3 channel 1.
// [RL12] Host never sets clock inversion while receiver power save is set.
// [RL13] Reference trim holds six bits [5:0] setting 800 mV to 1.2 V.
// [RL14] Channel-4 gain setting [6:0], two's complement, applies outside calibration.
// [RL15] Channel-4 gain bits [14:8] read only the calibration result.
// [RL16] Software reset reloads defaults of every register here.
// [RL17] Read-only fields ignore writes; reserved bits read zero.
module pcg_config_regs (
   // Clock, reset, enable
   input  wire logic                          clk_sys_in,
   input  wire logic                          reset_n_in,
   input  wire logic                          clk_en_in,
   input  wire logic                          soft_reset_in,
   // Register port from serial controller
   input  wire logic [pcg_pkg::ADDR_W-1:0]    reg_addr_in,
   input  wire logic [pcg_pkg::DATA_W-1:0]    reg_wdata_in,
   input  wire logic                          reg_wr_in,
   input  wire logic                          reg_rd_in,
   output logic      [pcg_pkg::DATA_W-1:0]    reg_rdata_out,
   output logic                               reg_rvalid_out,
   // Regulator status from analog
   input  wire pcg_pkg::pcg_pwr_flag_s        regulator_on_in,
   // Calibration engine
   input  wire logic                          calibration_mode_in,
   input  wire logic                          cal_done_in,
   input  wire logic [pcg_pkg::GAIN_W-1:0]    cal_result_in,
   // Controls to analog
   output pcg_pkg::pcg_pwr_ctl_s              pwr_ctl_out,
   output pcg_pkg::pcg_clk_ctl_s              clk_ctl_out,
   output logic      [pcg_pkg::TRIM_W-1:0]    bandgap_trim_out,
   output logic      [pcg_pkg::GAIN_W-1:0]    channel4_gain_out
);

   // ==========================================================
   // Regulator status synchroniser
   pcg_pkg::pcg_pwr_flag_s flags_sync;

   pcg_flag_sync #(
      .WIDTH (pcg_pkg::PWR_FLAG_W)
   ) u_flag_sync (
      .clk_sys_in (clk_sys_in),
      .reset_n_in (reset_n_in),
      .clk_en_in  (clk_en_in),
      .async_in   (regulator_on_in),
      .sync_out   (flags_sync)
   );

   // ==========================================================
   // State
   pcg_pkg::pcg_state_s state_ff;
   pcg_pkg::pcg_state_s nxt_state;
   logic                wr_power;
   logic                wr_clock;
   logic                wr_trim;
   logic                wr_gain;
   logic [pcg_pkg::DATA_W-1:0] read_word;

   assign wr_power = reg_wr_in && (reg_addr_in == pcg_pkg::OFS_POWER_CONTROL_STATUS);
   assign wr_clock = reg_wr_in && (reg_addr_in == pcg_pkg::OFS_CLOCK_CONTROL);
   assign wr_trim  = reg_wr_in && (reg_addr_in == pcg_pkg::OFS_REFERENCE_TRIM);
   assign wr_gain  = reg_wr_in && (reg_addr_in == pcg_pkg::OFS_CHANNEL4_ANALOG_GAIN);

   // ==========================================================
   // Read mux; unmapped and reserved bits read zero
   always_comb begin
      read_word = '0;
      case (reg_addr_in)
         pcg_pkg::OFS_POWER_CONTROL_STATUS: begin
            read_word[pcg_pkg::PWR_FLAG_LSB +: pcg_pkg::PWR_FLAG_W] = flags_sync;  // [RL1]
            read_word[pcg_pkg::PWR_CTL_LSB +: pcg_pkg::PWR_CTL_W]   = state_ff.pwr;
         end
         pcg_pkg::OFS_CLOCK_CONTROL: begin
            read_word[pcg_pkg::CLK_CTL_LSB +: pcg_pkg::CLK_CTL_W] = state_ff.clk;
         end
         pcg_pkg::OFS_REFERENCE_TRIM: begin
            read_word[pcg_pkg::TRIM_LSB +: pcg_pkg::TRIM_W] = state_ff.trim;
         end
         pcg_pkg::OFS_CHANNEL4_ANALOG_GAIN: begin
            read_word[pcg_pkg::GAIN_CAL_LSB +: pcg_pkg::GAIN_W] = state_ff.gain_cal;  // [RL15]
            read_word[pcg_pkg::GAIN_SET_LSB +: pcg_pkg::GAIN_W] = state_ff.gain_set;
         end
         default: begin
            read_word = '0;  // [RL17]
         end
      endcase
   end

   // ==========================================================
   // Next state
   always_comb begin
      nxt_state        = state_ff;
      nxt_state.rvalid = 1'b0;
      if (soft_reset_in) begin
         // Soft reset outranks a write in the same cycle
         nxt_state.pwr      = pcg_pkg::PWR_CTL_RST;   // [RL16]
         nxt_state.clk      = pcg_pkg::CLK_CTL_RST;   // [RL16]
         nxt_state.trim     = pcg_pkg::TRIM_RST;      // [RL16]
         nxt_state.gain_set = pcg_pkg::GAIN_SET_RST;  // [RL16]
         nxt_state.gain_cal = pcg_pkg::GAIN_CAL_RST;  // [RL16]
      end else begin
         if (wr_power) begin
            // Regulator, reference and sleep controls; flag bits are not stored
            nxt_state.pwr = pcg_pkg::pcg_pwr_ctl_s'(
               reg_wdata_in[pcg_pkg::PWR_CTL_LSB +: pcg_pkg::PWR_CTL_W]);  // [RL2] [RL3] [RL4] [RL5] [RL17]
         end
         if (wr_clock) begin
            // Inversion together with power save is the host's to avoid
            nxt_state.clk = pcg_pkg::pcg_clk_ctl_s'(
               reg_wdata_in[pcg_pkg::CLK_CTL_LSB +: pcg_pkg::CLK_CTL_W]);  // [RL6] [RL7] [RL8] [RL9] [RL10] [RL11]
         end
         if (wr_trim) begin
            nxt_state.trim = reg_wdata_in[pcg_pkg::TRIM_LSB +: pcg_pkg::TRIM_W];  // [RL13]
         end
         if (wr_gain) begin
            // Calibration field is never written from the port
            nxt_state.gain_set = reg_wdata_in[pcg_pkg::GAIN_SET_LSB +: pcg_pkg::GAIN_W];  // [RL14] [RL17]
         end
         if (cal_done_in) begin
            nxt_state.gain_cal = cal_result_in;  // [RL15]
         end
      end
      // Calibration owns the gain while it runs
      nxt_state.gain_applied = calibration_mode_in ? cal_result_in : nxt_state.gain_set;  // [RL14]
      if (reg_rd_in) begin
         nxt_state.rdata  = read_word;
         nxt_state.rvalid = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_ff.pwr          <= pcg_pkg::PWR_CTL_RST;
         state_ff.clk          <= pcg_pkg::CLK_CTL_RST;
         state_ff.trim         <= pcg_pkg::TRIM_RST;
         state_ff.gain_set     <= pcg_pkg::GAIN_SET_RST;
         state_ff.gain_cal     <= pcg_pkg::GAIN_CAL_RST;
         state_ff.gain_applied <= pcg_pkg::GAIN_SET_RST;
         state_ff.rdata        <= pcg_pkg::RDATA_RST;
         state_ff.rvalid       <= 1'b0;
      end else if (clk_en_in) begin
         state_ff <= nxt_state;
      end
   end

   // ==========================================================
   // Outputs
   assign pwr_ctl_out       = state_ff.pwr;
   assign clk_ctl_out       = state_ff.clk;
   assign bandgap_trim_out  = state_ff.trim;
   assign channel4_gain_out = state_ff.gain_applied;
   assign reg_rdata_out     = state_ff.rdata;
   assign reg_rvalid_out    = state_ff.rvalid;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!reset_n_in);

   a_soft_reset_defaults: assert property ( // [RL16]
      clk_en_in && soft_reset_in |=>
         pwr_ctl_out == pcg_pkg::PWR_CTL_RST && clk_ctl_out == pcg_pkg::CLK_CTL_RST &&
         bandgap_trim_out == pcg_pkg::TRIM_RST)
      else $error("soft reset did not reload defaults");

   a_power_write_lands: assert property ( // [RL2]
      clk_en_in && !soft_reset_in && wr_power |=>
         pwr_ctl_out == $past(reg_wdata_in[8:0]))
      else $error("power register write not applied");

   a_sleep_bit_order: assert property ( // [RL5]
      clk_en_in && !soft_reset_in && wr_power && reg_wdata_in[3:0] == 4'h8 |=>
         pwr_ctl_out.channel_output_off[3] && !pwr_ctl_out.channel_output_off[0])
      else $error("channel sleep bit order wrong");

   a_clock_write_lands: assert property ( // [RL11]
      clk_en_in && !soft_reset_in && wr_clock |=>
         (clk_ctl_out == $past(reg_wdata_in[11:0])) and
         (!(clk_en_in && (soft_reset_in || wr_clock)) |=> clk_ctl_out == $past(clk_ctl_out)))
      else $error("clock register write not held");

   a_trim_write_lands: assert property ( // [RL13]
      clk_en_in && !soft_reset_in && wr_trim |=> bandgap_trim_out == $past(reg_wdata_in[5:0]))
      else $error("trim write not applied");

   a_gain_applies: assert property ( // [RL14]
      clk_en_in && !calibration_mode_in && !soft_reset_in && wr_gain |=>
         channel4_gain_out == $past(reg_wdata_in[6:0]))
      else $error("gain setting not applied outside calibration");

   a_cal_field_ro: assert property ( // [RL17]
      clk_en_in && wr_gain && !cal_done_in && !soft_reset_in |=> $stable(state_ff.gain_cal))
      else $error("calibration field changed by a write");

   a_flag_readback: assert property ( // [RL1]
      clk_en_in && reg_rd_in && reg_addr_in == pcg_pkg::OFS_POWER_CONTROL_STATUS |=>
         reg_rvalid_out && reg_rdata_out[11:9] == $past(flags_sync))
      else $error("regulator flags not read back");

   a_reserved_zero: assert property ( // [RL17]
      reg_rvalid_out |-> reg_rdata_out[15] == 1'b0 && reg_rdata_out[14:12] == 3'h0 ||
         $past(reg_addr_in) == pcg_pkg::OFS_CHANNEL4_ANALOG_GAIN)
      else $error("reserved bits read nonzero");

   // ==========================================================
   // Field placement, one check per power and clock field except channel output off, two for clock invert (one for the three regulator-off bits)
   a_regulator_off_bits: assert property ( // [RL2]
      clk_en_in && !soft_reset_in && wr_power |=>
         {pwr_ctl_out.clock_regulator_off, pwr_ctl_out.digital1_regulator_off,
          pwr_ctl_out.digital2_regulator_off} == $past(reg_wdata_in[8:6]))
      else $error("regulator disable bits misplaced");

   a_ref_resistor_bit: assert property ( // [RL3]
      clk_en_in && !soft_reset_in && wr_power |=>
         pwr_ctl_out.ref_resistor_off == $past(reg_wdata_in[5]))
      else $error("reference resistor bit misplaced");

   a_bandgap_pdn_bit: assert property ( // [RL4]
      clk_en_in && !soft_reset_in && wr_power |=>
         pwr_ctl_out.bandgap_power_down == $past(reg_wdata_in[4]))
      else $error("bandgap power-down bit misplaced");

   a_analog_clock_bits: assert property ( // [RL6]
      clk_en_in && !soft_reset_in && wr_clock |=>
         clk_ctl_out.analog_clock_off == $past(reg_wdata_in[11:8]))
      else $error("analog clock gate bits misplaced");

   a_core_clock_bit: assert property ( // [RL7]
      clk_en_in && !soft_reset_in && wr_clock |=>
         clk_ctl_out.core_clock_gate == $past(reg_wdata_in[7]))
      else $error("core clock gate bit misplaced");

   a_clock_sleep_bit: assert property ( // [RL8]
      clk_en_in && !soft_reset_in && wr_clock |=>
         clk_ctl_out.clock_sleep == $past(reg_wdata_in[6]))
      else $error("clock sleep bit misplaced");

   a_receiver_off_bit: assert property ( // [RL9]
      clk_en_in && !soft_reset_in && wr_clock |=>
         clk_ctl_out.clock_receiver_off == $past(reg_wdata_in[5]))
      else $error("clock receiver power-down bit misplaced");

   a_power_save_bit: assert property ( // [RL10]
      clk_en_in && !soft_reset_in && wr_clock |=>
         clk_ctl_out.receiver_power_save == $past(reg_wdata_in[4]))
      else $error("receiver power save bit misplaced");

   a_invert_bits: assert property ( // [RL11]
      clk_en_in && !soft_reset_in && wr_clock |=>
         clk_ctl_out.clock_invert == $past(reg_wdata_in[3:0]))
      else $error("clock invert bits misplaced");

   a_invert_order: assert property ( // [RL11]
      clk_en_in && !soft_reset_in && wr_clock && reg_wdata_in[3:0] == 4'h8 |=>
         clk_ctl_out.clock_invert[3] && !clk_ctl_out.clock_invert[0])
      else $error("clock invert channel order wrong");

   // ==========================================================
   // Calibration, soft reset, decode and read port
   a_cal_result_load: assert property ( // [RL15]
      clk_en_in && cal_done_in && !soft_reset_in |=>
         state_ff.gain_cal == $past(cal_result_in))
      else $error("calibration result not captured");

   a_cal_gain_follows: assert property ( // [RL14]
      clk_en_in && calibration_mode_in |=>
         channel4_gain_out == $past(cal_result_in))
      else $error("calibration gain not applied");

   a_soft_reset_gain: assert property ( // [RL16]
      clk_en_in && soft_reset_in |=>
         state_ff.gain_cal == pcg_pkg::GAIN_CAL_RST && state_ff.gain_set == pcg_pkg::GAIN_SET_RST)
      else $error("soft reset left gain fields set");

   a_unmapped_write: assert property ( // [RL17]
      clk_en_in && reg_wr_in && (reg_addr_in == 16'h0000 || reg_addr_in > pcg_pkg::OFS_CHANNEL4_ANALOG_GAIN) |=>
         $stable(pwr_ctl_out) && $stable(clk_ctl_out) && $stable(bandgap_trim_out))
      else $error("unmapped write changed a register");

   a_unmapped_read: assert property ( // [RL17]
      clk_en_in && reg_rd_in && (reg_addr_in == 16'h0000 || reg_addr_in > pcg_pkg::OFS_CHANNEL4_ANALOG_GAIN) |=>
         reg_rdata_out == 16'h0000)
      else $error("unmapped read returned nonzero");

   a_trim_upper_zero: assert property ( // [RL13]
      clk_en_in && reg_rd_in && reg_addr_in == pcg_pkg::OFS_REFERENCE_TRIM |=>
         reg_rdata_out[15:6] == 10'h000)
      else $error("trim reserved bits read nonzero");

   a_gain_gap_zero: assert property ( // [RL17]
      clk_en_in && reg_rd_in && reg_addr_in == pcg_pkg::OFS_CHANNEL4_ANALOG_GAIN |=>
         !reg_rdata_out[15] && !reg_rdata_out[7])
      else $error("gain reserved bits read nonzero");

   // Valid is a one-cycle pulse; a held read or a low enable keeps it
   a_read_valid_pulse: assert property (clk_en_in && reg_rd_in |=> reg_rvalid_out)
      else $error("read valid missing");

   a_read_valid_drop: assert property (clk_en_in && !reg_rd_in |=> !reg_rvalid_out)
      else $error("read valid stayed high");

   a_enable_freeze: assert property (!clk_en_in |=> $stable(state_ff))
      else $error("state moved while enable low");

endmodule

//--- logic/pcg_flag_sync.sv
// Purpose : Two-stage synchroniser for asynchronous status levels
// Assumes : Inputs are slow levels from analog circuitry
// Notes   : First stage feeds only the second stage
module pcg_flag_sync #(
   parameter int WIDTH = 3
) (
   // Clock, reset, enable
   input  wire logic             clk_sys_in,
   input  wire logic             reset_n_in,
   input  wire logic             clk_en_in,
   // Levels
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } pcg_sync_s;

   pcg_sync_s sync_ff;
   pcg_sync_s nxt_sync;

   always_comb begin
      nxt_sync = sync_ff;
      if (clk_en_in) begin
         nxt_sync.stage1 = async_in;
         nxt_sync.stage2 = sync_ff.stage1;
      end
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sync_ff <= '0;
      end else begin
         sync_ff <= nxt_sync;
      end
   end

   assign sync_out = sync_ff.stage2;

endmodule

//--- logic/pcg_pkg.sv
// Purpose : Shared constants and carriers for the power, clock and gain configuration registers
// Assumes : 16-bit register words, register addresses as seen by the serial-port controller
// Notes   : All reset values are zero; field layouts match the register word bit positions
package pcg_pkg;

   // ==========================================================
   // Register access widths
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;

   // ==========================================================
   // Register offsets
   localparam logic [ADDR_W-1:0] OFS_POWER_CONTROL_STATUS = 16'h0001;
   localparam logic [ADDR_W-1:0] OFS_CLOCK_CONTROL        = 16'h0002;
   localparam logic [ADDR_W-1:0] OFS_REFERENCE_TRIM       = 16'h0003;
   localparam logic [ADDR_W-1:0] OFS_CHANNEL4_ANALOG_GAIN = 16'h0004;

   // ==========================================================
   // Field positions and widths
   localparam int PWR_FLAG_LSB  = 9;
   localparam int PWR_FLAG_W    = 3;
   localparam int PWR_CTL_LSB   = 0;
   localparam int PWR_CTL_W     = 9;
   localparam int CLK_CTL_LSB   = 0;
   localparam int CLK_CTL_W     = 12;
   localparam int TRIM_LSB      = 0;
   localparam int TRIM_W        = 6;
   localparam int GAIN_SET_LSB  = 0;
   localparam int GAIN_CAL_LSB  = 8;
   localparam int GAIN_W        = 7;
   localparam int NUM_CHANNELS  = 4;

   // ==========================================================
   // Carriers; index 3 of each per-channel vector is channel 1
   typedef struct packed {
      logic                    clock_regulator_off;
      logic                    digital1_regulator_off;
      logic                    digital2_regulator_off;
      logic                    ref_resistor_off;
      logic                    bandgap_power_down;
      logic [NUM_CHANNELS-1:0] channel_output_off;
   } pcg_pwr_ctl_s;

   typedef struct packed {
      logic                    clock_regulator_on_flag;
      logic                    digital1_regulator_on_flag;
      logic                    digital2_regulator_on_flag;
   } pcg_pwr_flag_s;

   typedef struct packed {
      logic [NUM_CHANNELS-1:0] analog_clock_off;
      logic                    core_clock_gate;
      logic                    clock_sleep;
      logic                    clock_receiver_off;
      logic                    receiver_power_save;
      logic [NUM_CHANNELS-1:0] clock_invert;
   } pcg_clk_ctl_s;

   // ==========================================================
   // Reset values
   localparam pcg_pwr_ctl_s        PWR_CTL_RST  = 9'h000;
   localparam pcg_clk_ctl_s        CLK_CTL_RST  = 12'h000;
   localparam logic [TRIM_W-1:0]   TRIM_RST     = 6'h00;
   localparam logic [GAIN_W-1:0]   GAIN_SET_RST = 7'h00;
   localparam logic [GAIN_W-1:0]   GAIN_CAL_RST = 7'h00;
   localparam logic [DATA_W-1:0]   RDATA_RST    = 16'h0000;

   // ==========================================================
   // Block state
   typedef struct packed {
      pcg_pwr_ctl_s        pwr;
      pcg_clk_ctl_s        clk;
      logic [TRIM_W-1:0]   trim;
      logic [GAIN_W-1:0]   gain_set;
      logic [GAIN_W-1:0]   gain_cal;
      logic [GAIN_W-1:0]   gain_applied;
      logic [DATA_W-1:0]   rdata;
      logic                rvalid;
   } pcg_state_s;

endpackage

//--- testbench/pcg_config_regs_test.sv
// Purpose : Self-checking bench for the configuration register block
// Assumes : Regulator flags settle through two enabled edges
// Notes   : Shadow copies of the registers, with the regulator flags and expected calibration result, predict every read and output
module pcg_config_regs_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_sys_in = 1'b0, reset_n_in = 1'b0, clk_en_in = 1'b1, soft_reset_in = 1'b0;
   logic cal_mode = 1'b0, cal_done = 1'b0;
   logic [6:0] cal_res = 7'h00;
   logic [6:0] cal_exp = 7'h00;
   pcg_pkg::pcg_pwr_flag_s reg_on = 3'h0;
   logic [15:0] addr, wdata, rdata, q, d;
   logic wr, rd, rvalid, vld;
   pcg_pkg::pcg_pwr_ctl_s pwr_ctl;
   pcg_pkg::pcg_clk_ctl_s clk_ctl;
   logic [5:0] trim;
   logic [6:0] gain;
   logic [15:0] shadow [0:7];
   int error_cnt = 0, compares = 0, cycles = 0, i;
   integer seed = 32'hc810;

   always #5 clk_sys_in = ~clk_sys_in;

   pcg_host_model u_host (.clk_sys_in(clk_sys_in), .reg_addr_out(addr), .reg_wdata_out(wdata),
      .reg_wr_out(wr), .reg_rd_out(rd), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid));

   pcg_config_regs u_dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
      .soft_reset_in(soft_reset_in), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .regulator_on_in(reg_on),
      .calibration_mode_in(cal_mode), .cal_done_in(cal_done), .cal_result_in(cal_res),
      .pwr_ctl_out(pwr_ctl), .clk_ctl_out(clk_ctl), .bandgap_trim_out(trim),
      .channel4_gain_out(gain));

   // ==========================================================
   // Expectations and checks
   function automatic logic [15:0] exp_rd(input logic [15:0] a);
      case (a)
         16'h0001: exp_rd = {4'h0, reg_on, shadow[1][8:0]};
         16'h0002: exp_rd = {4'h0, shadow[2][11:0]};
         16'h0003: exp_rd = {10'h000, shadow[3][5:0]};
         16'h0004: exp_rd = {1'b0, cal_exp, 1'b0, shadow[4][6:0]};
         default:  exp_rd = 16'h0000;
      endcase
   endfunction

   task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (e !== g) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic w(input logic [15:0] a, input logic [15:0] v);
      if (a === 16'h0002 && v[4]) v[3:0] = 4'h0;
      u_host.wr(a, v);
      if (a >= 16'h0001 && a <= 16'h0004) shadow[a[2:0]] = v;
   endtask

   task automatic r(input logic [15:0] a);
      u_host.rd(a, q, vld);
      chk("rvalid", 16'h0001, {15'h0000, vld});
      chk("rdata", exp_rd(a), q);
   endtask

   task automatic chk_outs();
      #1;
      chk("pwr_ctl", {7'h00, shadow[1][8:0]}, {7'h00, pwr_ctl});
      chk("clk_ctl", {4'h0, shadow[2][11:0]}, {4'h0, clk_ctl});
      chk("trim", {10'h000, shadow[3][5:0]}, {10'h000, trim});
      chk("gain", {9'h000, shadow[4][6:0]}, {9'h000, gain});
   endtask

   task automatic read_all();
      for (int k = 1; k <= 5; k++) r(16'(k));
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Ceiling well above the few hundred cycles the tests need
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 6000) begin
         error_cnt++;
         end_sim();
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      for (i = 0; i < 8; i++) shadow[i] = 16'h0000;
      repeat (2) @(posedge clk_sys_in);
      reset_n_in <= 1'b1;
      read_all();
      chk_outs();
      $display("test reset values done");

      for (i = 0; i < 60; i++) begin
         d = 16'($random(seed));
         if (i < 4) d = 16'hffff;
         w(16'((i % 7) + 1), d);
         chk_outs();
         r(16'(($random(seed) & 7)));
      end
      w(16'h0001, 16'h0008);
      chk_outs();
      w(16'h0002, 16'h0808);
      chk_outs();
      w(16'h0002, 16'h001f);
      chk_outs();
      $display("test random access done");

      @(posedge clk_sys_in);
      reg_on <= 3'($random(seed)) | 3'h4;
      repeat (3) @(posedge clk_sys_in);
      r(16'h0001);
      w(16'h0001, 16'hffff);
      r(16'h0001);
      $display("test regulator flags done");

      @(posedge clk_sys_in);
      cal_res  <= 7'h55;
      cal_done <= 1'b1;
      @(posedge clk_sys_in);
      cal_done <= 1'b0;
      cal_exp = 7'h55;
      w(16'h0004, 16'h7f2a);
      r(16'h0004);
      @(posedge clk_sys_in);
      cal_mode <= 1'b1;
      cal_res  <= 7'h33;
      repeat (2) @(posedge clk_sys_in);
      #1;
      chk("gain cal", 16'h0033, {9'h000, gain});
      @(posedge clk_sys_in);
      cal_mode <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      chk_outs();
      $display("test calibration done");

      @(posedge clk_sys_in);
      clk_en_in <= 1'b0;
      u_host.wr(16'h0003, 16'h0015);
      @(posedge clk_sys_in);
      clk_en_in <= 1'b1;
      r(16'h0003);
      $display("test clock enable done");

      @(posedge clk_sys_in);
      soft_reset_in <= 1'b1;
      @(posedge clk_sys_in);
      soft_reset_in <= 1'b0;
      for (i = 1; i <= 4; i++) shadow[i] = 16'h0000;
      cal_exp = 7'h00;
      chk_outs();
      read_all();
      $display("test soft reset done");
      end_sim();
   end
endmodule

//--- testbench/pcg_host_model.sv
// Purpose : Host that configures the block through its parallel register port
// Assumes : One transfer per task call, strobe held for exactly one clock edge, enabled or not
// Notes   : Idle address and data are inverted so stale values never look valid
module pcg_host_model (
   // Clock
   input  wire logic                       clk_sys_in,
   // Register port
   output logic      [pcg_pkg::ADDR_W-1:0] reg_addr_out,
   output logic      [pcg_pkg::DATA_W-1:0] reg_wdata_out,
   output logic                            reg_wr_out,
   output logic                            reg_rd_out,
   input  wire logic [pcg_pkg::DATA_W-1:0] reg_rdata_in,
   input  wire logic                       reg_rvalid_in
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      reg_addr_out  = 16'h0000;
      reg_wdata_out = 16'h0000;
      reg_wr_out    = 1'b0;
      reg_rd_out    = 1'b0;
   end

   // ==========================================================
   // Transfers
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      logic [15:0] v;
      v = d;
      // Inversion never issued together with receiver power save
      if (a === pcg_pkg::OFS_CLOCK_CONTROL && d[4]) v[3:0] = 4'h0;
      @(posedge clk_sys_in);
      reg_addr_out  <= a;
      reg_wdata_out <= v;
      reg_wr_out    <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr_out    <= 1'b0;
      reg_addr_out  <= ~a;
      reg_wdata_out <= ~v;
   endtask

   task automatic rd(input logic [15:0] a, output logic [15:0] q, output logic vld);
      @(posedge clk_sys_in);
      reg_addr_out <= a;
      reg_rd_out   <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd_out   <= 1'b0;
      reg_addr_out <= ~a;
      #1;
      q   = reg_rdata_in;
      vld = reg_rvalid_in;
   endtask
endmodule
